//--- spims_pkg.sv
// constants for the spi master/slave port
//
// Contract
// - block runs as master or slave per configuration, never both
// - slave takes serial clock, data and select; select may be forced
// - a transfer is eight bits with eight master clock pulses
// - both ends shift out and in together; master may drop received bits
// - master supports clock modes zero to three
// - msb first by default, lsb first by option, both roles
// - master uses shifter, transmit holding and receive holding registers
// - input capture holds each bit half a period, opposite edge
// - master makes the bit clock from the selected system clock divide
// - master drives no slave select output
// - rx buffer writes ignored; tx buffer reads return no data
// - interrupt from tx empty (default) or transfer complete
// - complete flag cleared only by a status read; no new interrupt meanwhile
// - slave takes all shift clocking from the incoming serial clock
// - slave shifts only while its low-active select is asserted
// - in modes 0 and 1 select edges queue the next tx byte
// - slave select comes from the pin or a software bit
// - deselected slave ignores pins, resets state, holds miso high
// - pin inputs are two-stage synchronised unless bypassed
// - clock select 000b..111b divides system clock by 2..256
// - tx write while idle starts transfer next edge, else it is buffered
// - overrun set when a byte arrives before the previous is read
// - phase 1 changes data on leading edge; polarity 1 idles high
package spims_pkg;
  localparam int          SPIMS_BITS     = 8;
  localparam logic [3:0]  SPIMS_LAST_BIT = 4'h7;
  localparam logic [7:0]  SPIMS_DIV_ONE  = 8'h01;
  localparam logic [7:0]  SPIMS_ZERO_B   = 8'h00;
  localparam int          SPIMS_FIFO_DEPTH = 16;
endpackage

//--- spims_fifo_if.sv
// interface carrying the receive byte stream into the buffer
`timescale 1ns/10ps
interface spims_fifo_if #(parameter int WIDTH = 8);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface

//--- spims_fifo.sv
// parameterised receive fifo with valid/ready on both sides
`timescale 1ns/10ps
module spims_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic  clk_i,
  input  wire logic  reset_n_i,
  spims_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              do_push = q.push_valid && q.push_ready;
  wire              do_pop  = q.pop_valid && q.pop_ready;

  // full and empty straight from the occupancy count
  assign q.push_ready = (count_reg != (AW+1)'(DEPTH));
  assign q.pop_valid  = (count_reg != '0);
  assign q.pop_data   = mem[rd_ptr_reg];

  // storage has no reset, pointers do
  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem[wr_ptr_reg] <= q.push_data;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      if (do_pop)
        rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
      count_reg <= (AW+1)'(count_reg + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop});
    end
  end
endmodule

//--- spims_core.sv
// spi master/slave port: pins, shifter, holding buffers, status
`timescale 1ns/10ps
module spims_core #(
  parameter int FIFO_DEPTH = spims_pkg::SPIMS_FIFO_DEPTH
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // configuration and control
  input  wire logic       enable_i,
  input  wire logic       slave_role_i,
  input  wire logic       lsb_first_i,
  input  wire logic       clk_phase_i,
  input  wire logic       clk_polarity_i,
  input  wire logic [2:0] clock_sel_i,
  input  wire logic       sync_bypass_bit_i,
  input  wire logic       ss_force_n_i,
  input  wire logic       ss_level_i,
  input  wire logic       int_sel_i,
  // cpu data access
  input  wire logic       tx_write_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       rx_read_i,
  input  wire logic       rx_write_i,
  input  wire logic       status_read_i,
  output logic      [7:0] rx_data_o,
  output logic      [7:0] tx_read_data_o,
  output logic            tx_empty_o,
  output logic            rx_full_o,
  output logic            complete_o,
  output logic            overrun_o,
  output logic            irq_o,
  // pins
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       miso_i,
  input  wire logic       ss_n_i,
  output logic            sclk_o,
  output logic            sclk_oe_o,
  output logic            mosi_o,
  output logic            mosi_oe_o,
  output logic            miso_o,
  output logic            miso_oe_o
);

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPIMS_IDLE  = 3'b001,
    SPIMS_LEAD  = 3'b010,
    SPIMS_TRAIL = 3'b100
  } spims_state_t;

  spims_state_t state_reg;
  spims_state_t state_next;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  wire  [3:0] raw_pins = {ss_n_i, miso_i, mosi_i, sclk_i};

  // two flops per pin; first stage only feeds the second
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      sync1_reg <= 4'hD;
      sync2_reg <= 4'hD;
    end
    else
    begin
      sync1_reg <= raw_pins;
      sync2_reg <= sync1_reg;
    end
  end

  // bypass picks the raw pins (caller owns metastability then)
  wire [3:0] pins  = sync_bypass_bit_i ? raw_pins : sync2_reg;
  wire       s_sclk = pins[0];
  wire       s_mosi = pins[1];
  wire       s_miso = pins[2];
  wire       s_ssn  = pins[3];

  // ----------------------------------------------------------------
  // role and select decode
  // ----------------------------------------------------------------
  wire is_master = enable_i && !slave_role_i;
  wire is_slave  = enable_i && slave_role_i;
  wire ss_eff_n  = ss_force_n_i ? s_ssn : ss_level_i;
  wire selected  = is_slave && !ss_eff_n;

  // ----------------------------------------------------------------
  // master bit clock divider
  // ----------------------------------------------------------------
  logic [7:0] div_cnt_reg;
  // half period = 2^sel system clocks, full period = 2^(sel+1)
  wire  [7:0] half_cnt = 8'(spims_pkg::SPIMS_DIV_ONE << clock_sel_i);
  wire        half_tick = (div_cnt_reg == 8'(half_cnt - 8'h01));

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || state_reg == SPIMS_IDLE)
      div_cnt_reg <= spims_pkg::SPIMS_ZERO_B;
    else
      div_cnt_reg <= half_tick ? spims_pkg::SPIMS_ZERO_B : 8'(div_cnt_reg + 8'h01);
  end

  // ----------------------------------------------------------------
  // slave clock edge detect (on the synchronised or bypassed level)
  // ----------------------------------------------------------------
  logic sclk_prev_reg;
  logic ssn_prev_reg;
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      sclk_prev_reg <= 1'b0;
      ssn_prev_reg  <= 1'b1;
    end
    else
    begin
      sclk_prev_reg <= s_sclk;
      ssn_prev_reg  <= ss_eff_n;
    end
  end

  // leading edge leaves idle level; polarity 1 idles high
  wire s_lead  = selected && (s_sclk != sclk_prev_reg) && (sclk_prev_reg == clk_polarity_i);
  wire s_trail = selected && (s_sclk != sclk_prev_reg) && (sclk_prev_reg != clk_polarity_i);
  wire ss_fall = is_slave && ssn_prev_reg && !ss_eff_n;

  // ----------------------------------------------------------------
  // unified edge strobes
  // ----------------------------------------------------------------
  wire m_lead  = is_master && half_tick && state_reg == SPIMS_LEAD;
  wire m_trail = is_master && half_tick && state_reg == SPIMS_TRAIL;
  wire e_lead  = m_lead || s_lead;
  wire e_trail = m_trail || s_trail;
  // phase 1 shifts on leading, samples on trailing; phase 0 the reverse
  wire e_shift  = clk_phase_i ? e_lead : e_trail;
  wire e_sample = clk_phase_i ? e_trail : e_lead;
  wire data_in  = is_master ? s_miso : s_mosi;

  // ----------------------------------------------------------------
  // datapath registers
  // ----------------------------------------------------------------
  logic [7:0] shifter_reg;
  logic [7:0] tx_holding_buf;
  logic       rxd_reg;
  logic [3:0] bit_cnt_reg;
  logic       busy_reg;
  logic       out_bit_reg;
  logic       sclk_reg;

  wire last_bit  = (bit_cnt_reg == spims_pkg::SPIMS_LAST_BIT);
  // byte done on the eighth trailing edge in every mode
  wire byte_done = last_bit && e_trail && busy_reg;
  // phase 1: first bit already stands after load, so the first leading edge must not shift
  wire do_shift  = e_shift && (busy_reg || is_slave) && !(clk_phase_i && bit_cnt_reg == '0);
  wire m_start   = is_master && state_reg == SPIMS_IDLE && !tx_empty_o;
  // slave loads on select fall (modes 0/1 need it) or at byte end
  wire s_load    = (ss_fall || (is_slave && byte_done)) && !tx_empty_o;
  wire load      = m_start || (is_master && byte_done && !tx_empty_o) || s_load;

  function automatic logic [7:0] spims_shift(input logic [7:0] v, input logic b, input logic lsb);
    spims_shift = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  function automatic logic spims_head(input logic [7:0] v, input logic lsb);
    spims_head = lsb ? v[0] : v[7];
  endfunction

  wire [7:0] shifted   = spims_shift(shifter_reg, rxd_reg, lsb_first_i);
  wire [7:0] rx_byte   = clk_phase_i ? spims_shift(shifter_reg, e_sample ? data_in : rxd_reg, lsb_first_i)
                                     : shifted;
  // next shifter value, so the data pin moves in the same cycle as the clock pin
  wire [7:0] shift_next = load ? tx_holding_buf : ((do_shift && !byte_done) ? shifted : shifter_reg);

  // state machine for master framing
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SPIMS_IDLE:  if (m_start || (is_master && busy_reg)) state_next = SPIMS_LEAD;
      SPIMS_LEAD:  if (m_lead) state_next = SPIMS_TRAIL;
      SPIMS_TRAIL: if (m_trail) state_next = (last_bit && tx_empty_o) ? SPIMS_IDLE : SPIMS_LEAD;
    endcase
    if (!is_master)
      state_next = SPIMS_IDLE;
  end

  // shift, capture and count
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || (is_slave && ss_eff_n) || !enable_i)
    begin
      state_reg   <= SPIMS_IDLE;
      shifter_reg <= 8'hFF;
      rxd_reg     <= 1'b0;
      bit_cnt_reg <= 4'h0;
      busy_reg    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (e_sample)
        rxd_reg <= data_in;
      if (load)
      begin
        shifter_reg <= tx_holding_buf;
        busy_reg    <= 1'b1;
        bit_cnt_reg <= 4'h0;
      end
      else if (byte_done)
        busy_reg <= 1'b0;
      else
      begin
        // shifts follow the phase; the count follows trailing edges
        if (do_shift)
          shifter_reg <= shifted;
        if (e_trail && (busy_reg || is_slave))
          bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // cpu side status and receive stream
  // ----------------------------------------------------------------
  spims_fifo_if #(.WIDTH(spims_pkg::SPIMS_BITS)) rxq ();
  spims_fifo #(.WIDTH(spims_pkg::SPIMS_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .q         (rxq)
  );
  assign rxq.push_valid = byte_done;
  assign rxq.push_data  = rx_byte;
  // drain into rx holding buffer once software has taken the last one
  assign rxq.pop_ready  = !rx_full_o || rx_read_i;

  // flags: hardware set wins over software clear
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      tx_holding_buf <= spims_pkg::SPIMS_ZERO_B;
      tx_empty_o     <= 1'b1;
      rx_full_o      <= 1'b0;
      rx_data_o      <= spims_pkg::SPIMS_ZERO_B;
      complete_o     <= 1'b0;
      overrun_o      <= 1'b0;
    end
    else
    begin
      if (tx_write_i)
      begin
        tx_holding_buf <= tx_data_i;
        tx_empty_o     <= 1'b0;
      end
      if (load)
        tx_empty_o <= 1'b1;
      if (rxq.pop_valid && rxq.pop_ready)
      begin
        rx_data_o <= rxq.pop_data; // write port ignored
        rx_full_o <= 1'b1;
      end
      else if (rx_read_i)
        rx_full_o <= 1'b0;
      if (byte_done)
        complete_o <= 1'b1;
      else if (status_read_i)
        complete_o <= 1'b0;
      if (byte_done && (rx_full_o || rxq.pop_valid) && !rx_read_i)
        overrun_o <= 1'b1;
      else if (status_read_i)
        overrun_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      sclk_reg       <= 1'b0;
      out_bit_reg    <= 1'b1;
      sclk_o         <= 1'b0;
      sclk_oe_o      <= 1'b0;
      mosi_o         <= 1'b1;
      mosi_oe_o      <= 1'b0;
      miso_o         <= 1'b1;
      miso_oe_o      <= 1'b0;
      irq_o          <= 1'b0;
      tx_read_data_o <= spims_pkg::SPIMS_ZERO_B;
    end
    else
    begin
      // sclk toggles on each half tick away from idle polarity
      sclk_reg    <= (state_next == SPIMS_TRAIL) ? !clk_polarity_i : clk_polarity_i;
      out_bit_reg <= spims_head(shift_next, lsb_first_i);
      sclk_o      <= sclk_reg;
      sclk_oe_o   <= is_master;
      mosi_o      <= out_bit_reg;
      mosi_oe_o   <= is_master;                 // no select driven
      miso_o      <= selected ? out_bit_reg : 1'b1;
      miso_oe_o   <= is_slave;
      irq_o       <= int_sel_i ? complete_o : tx_empty_o;
      tx_read_data_o <= spims_pkg::SPIMS_ZERO_B;
    end
  end

  // rx_write_i is accepted and deliberately has no effect
  wire unused_ok = rx_write_i;
endmodule

//--- spims_monitor.sv
// assertion checker on the spi port top level
`timescale 1ns/10ps
module spims_monitor (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       slave_role_i,
  input wire logic       clk_polarity_i,
  input wire logic [2:0] clock_sel_i,
  input wire logic       ss_force_n_i,
  input wire logic       ss_n_i,
  input wire logic       int_sel_i,
  input wire logic       tx_write_i,
  input wire logic       rx_read_i,
  input wire logic       rx_write_i,
  input wire logic       status_read_i,
  input wire logic [7:0] rx_data_o,
  input wire logic [7:0] tx_read_data_o,
  input wire logic       tx_empty_o,
  input wire logic       complete_o,
  input wire logic       irq_o,
  input wire logic       sclk_o,
  input wire logic       sclk_oe_o,
  input wire logic       mosi_oe_o,
  input wire logic       miso_o
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // a slave never drives the master pins
  oe_master_a: assert property (slave_role_i && $past(slave_role_i) |-> !sclk_oe_o && !mosi_oe_o)
    else $error("master pins driven in slave role");
  // sync plus register delay fits in five cycles
  miso_idle_a: assert property ((slave_role_i && ss_force_n_i && ss_n_i)[*5] |-> miso_o)
    else $error("deselected slave not idling high");
  tx_clear_a: assert property (tx_write_i |=> !tx_empty_o)
    else $error("tx write did not clear empty");
  sclk_idle_a: assert property ($rose(complete_o) && !slave_role_i && tx_empty_o |=> sclk_o == clk_polarity_i)
    else $error("clock not idle after transfer");
  // guard keeps the first edge after reset out
  irq_src_a: assert property ($past(reset_n_i) |-> irq_o == $past(int_sel_i ? complete_o : tx_empty_o))
    else $error("interrupt source wrong");
  done_clear_a: assert property (status_read_i |=> !complete_o)
    else $error("status read left complete set");
  rx_write_a: assert property (rx_write_i && !rx_read_i |=> $stable(rx_data_o) && tx_read_data_o == 8'h00)
    else $error("rx write or tx read leaked");
  sclk_rate_a: assert property ($rose(sclk_o) && !slave_role_i && !clk_polarity_i && clock_sel_i == 3'h1
    |=> sclk_o ##1 !sclk_o)
    else $error("half period wrong for divide by four");
endmodule

//--- spims_slave_model.sv
// behavioural spi slave on the far side of the master port
`timescale 1ns/10ps
module spims_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_i,
  input  wire logic       load_i,
  input  wire logic [7:0] seed_i,
  output logic            miso_o,
  output logic      [7:0] rx_o,
  output int              count_o
);
  logic [7:0] tx;
  logic [7:0] sh;
  int         ob;
  int         ib;
  // ----------------------------------------
  // shifting
  // ----------------------------------------
  // restart; first bit ready before the first edge
  always @(posedge load_i)
  begin
    tx = seed_i;
    ob = 0;
    ib = 0;
    count_o = 0;
    miso_o = lsb_i ? tx[0] : tx[7];
  end
  // out and in together; each byte gives the next reply
  always @(sclk_i)
  begin
    if ((sclk_i !== cpol_i) == !cpha_i)
    begin
      sh[lsb_i ? ib : 7 - ib] = mosi_i;
      ib = ib + 1;
      if (ib == 8)
      begin
        rx_o = sh;
        count_o++;
        ib = 0;
      end
    end
    else
    begin
      if (!cpha_i)
        ob = ob + 1;
      if (ob == 8)
      begin
        ob = 0;
        tx = tx + 8'h11;
      end
      miso_o = lsb_i ? tx[ob] : tx[7 - ob];
      if (cpha_i)
        ob = ob + 1;
    end
  end
endmodule

//--- testbench.sv
// self-checking bench for the spi master/slave port
`timescale 1ns/10ps
module testbench;
  logic       clk_i = 1'b0, reset_n_i = 1'b0, enable_i = 1'b0, slave_role_i = 1'b0;
  logic       lsb_first_i = 1'b0, clk_phase_i = 1'b0, clk_polarity_i = 1'b0;
  logic [2:0] clock_sel_i = 3'h0;
  logic       sync_bypass_bit_i = 1'b0, ss_force_n_i = 1'b1, ss_level_i = 1'b1, int_sel_i = 1'b0;
  logic       tx_write_i = 1'b0, rx_read_i = 1'b0, rx_write_i = 1'b0, status_read_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic       sclk_i = 1'b0, mosi_i = 1'b0, ss_n_i = 1'b1, load = 1'b0;
  logic [7:0] rx_data_o, tx_read_data_o, m_rx, seed, got;
  logic       tx_empty_o, rx_full_o, complete_o, overrun_o, irq_o, miso_m;
  logic       sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  int         m_cnt, k;
  int         num_errors = 0;
  int         comparisons = 0;
  int         cycles = 0;

  spims_core dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .enable_i(enable_i), .slave_role_i(slave_role_i),
    .lsb_first_i(lsb_first_i), .clk_phase_i(clk_phase_i), .clk_polarity_i(clk_polarity_i),
    .clock_sel_i(clock_sel_i), .sync_bypass_bit_i(sync_bypass_bit_i), .ss_force_n_i(ss_force_n_i),
    .ss_level_i(ss_level_i), .int_sel_i(int_sel_i), .tx_write_i(tx_write_i), .tx_data_i(tx_data_i),
    .rx_read_i(rx_read_i), .rx_write_i(rx_write_i), .status_read_i(status_read_i), .rx_data_o(rx_data_o),
    .tx_read_data_o(tx_read_data_o), .tx_empty_o(tx_empty_o), .rx_full_o(rx_full_o),
    .complete_o(complete_o), .overrun_o(overrun_o), .irq_o(irq_o), .sclk_i(sclk_i), .mosi_i(mosi_i),
    .miso_i(miso_m), .ss_n_i(ss_n_i), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o), .miso_o(miso_o), .miso_oe_o(miso_oe_o));

  spims_slave_model peer (.sclk_i(sclk_o), .mosi_i(mosi_o), .cpol_i(clk_polarity_i), .cpha_i(clk_phase_i),
    .lsb_i(lsb_first_i), .load_i(load), .seed_i(seed), .miso_o(miso_m), .rx_o(m_rx), .count_o(m_cnt));

  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  // whole run is about six thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // one-cycle strobe launched at a falling edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  // bounded wait, then the level itself is checked
  task automatic wait_hi(ref logic s);
    k = 0;
    while (s !== 1'b1 && k < 4000)
    begin
      tick(1);
      k++;
    end
    check({7'h00, s}, 8'h01);
  endtask
  task automatic mxfer(input logic [7:0] d);
    wait_hi(tx_empty_o);
    tx_data_i = d;
    pulse(tx_write_i);
  endtask
  task automatic end_sim();
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // mode 0 master in the bench; select from pin or forced bit
  task automatic sxfer(input logic frc);
    slave_role_i = 1'b1;
    ss_force_n_i = !frc;
    tick(8);
    check({7'h00, miso_o}, 8'h01);
    tx_data_i = 8'hC3;
    pulse(tx_write_i);
    ss_n_i = frc;
    ss_level_i = 1'b0;
    tick(8);
    for (int b = 7; b >= 0; b--)
    begin
      mosi_i = b[0] ^ b[2];
      tick(8);
      got[b] = miso_o;
      sclk_i = 1'b1;
      tick(8);
      sclk_i = 1'b0;
    end
    tick(8);
    ss_n_i = 1'b1;
    ss_level_i = 1'b1;
    check(got, 8'hC3);
    check(rx_data_o, 8'h5A);
    pulse(rx_read_i);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    tick(2);
    reset_n_i = 1'b1;
    enable_i = 1'b1;
    tick(2);
    check({6'h00, complete_o, tx_empty_o}, 8'h01);
    // every mode, both bit orders; the round trip through pins and syncs limits the fastest divider
    for (int i = 0; i < 8; i++)
    begin
      {clk_polarity_i, clk_phase_i} = i[1:0];
      lsb_first_i = i[2];
      clock_sel_i = (i < 2) ? 3'h1 : 3'(i);
      sync_bypass_bit_i = (i < 2);
      int_sel_i = i[0];
      seed = 8'h3C + 8'(i);
      tick(4);
      pulse(load);
      mxfer(8'h96 ^ 8'(i * 37));
      wait_hi(complete_o);
      tick(6);
      check(m_rx, 8'h96 ^ 8'(i * 37));
      check(rx_data_o, seed);
      pulse(rx_write_i);
      check(rx_data_o, seed);
      pulse(status_read_i);
      check({7'h00, complete_o}, 8'h00);
      pulse(rx_read_i);
      tick(1);
      check({7'h00, rx_full_o}, 8'h00);
    end
    // back-to-back bytes until the receive fifo and the rx holding buffer are both full
    {clk_polarity_i, clk_phase_i, lsb_first_i} = 3'h0;
    clock_sel_i = 3'h2;
    seed = 8'h20;
    tick(4);
    pulse(load);
    for (int n = 0; n < 17; n++)
      mxfer(8'h40 + 8'(n));
    k = 0;
    while (m_cnt != 17 && k < 2000)
    begin
      tick(1);
      k++;
    end
    tick(8);
    check(m_rx, 8'h50);
    check({7'h00, overrun_o}, 8'h01);
    for (int n = 0; n < 17; n++)
    begin
      check(rx_data_o, 8'h20 + 8'(n * 17));
      pulse(rx_read_i);
      tick(1);
    end
    check({7'h00, rx_full_o}, 8'h00);
    pulse(status_read_i);
    check({7'h00, overrun_o}, 8'h00);
    sync_bypass_bit_i = 1'b0;
    sxfer(1'b0);
    tick(2);
    sxfer(1'b1);
    end_sim();
  end
endmodule

bind spims_core spims_monitor mon (.clk_i(clk_i), .reset_n_i(reset_n_i), .slave_role_i(slave_role_i),
  .clk_polarity_i(clk_polarity_i), .clock_sel_i(clock_sel_i), .ss_force_n_i(ss_force_n_i), .ss_n_i(ss_n_i),
  .int_sel_i(int_sel_i), .tx_write_i(tx_write_i), .rx_read_i(rx_read_i), .rx_write_i(rx_write_i),
  .status_read_i(status_read_i), .rx_data_o(rx_data_o), .tx_read_data_o(tx_read_data_o),
  .tx_empty_o(tx_empty_o), .complete_o(complete_o), .irq_o(irq_o), .sclk_o(sclk_o),
  .sclk_oe_o(sclk_oe_o), .mosi_oe_o(mosi_oe_o), .miso_o(miso_o));
